// *** rtl/ssr_pkg.sv ***
// shared constants and types of the status summary and service request block
package ssr_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int STB_W = 8;
   localparam int STD_W = 8;
   localparam int DEV_W = 16;
   localparam int DATA_W = 16;

   // ------------------------------------------------------------
   // status byte field positions
   // ------------------------------------------------------------
   localparam int STB_DEV_SUM_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_STD_SUM_BIT = 5;
   localparam int STB_MSS_BIT = 6;

   // ------------------------------------------------------------
   // implemented event bits, unused bits always read zero
   // ------------------------------------------------------------
   localparam logic [STD_W-1:0] STD_USED = 8'hB9;
   localparam logic [DEV_W-1:0] DEV_USED = 16'hFFF7;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [STB_W-1:0] STB_RST = 8'h00;
   localparam logic [STB_W-1:0] SRQ_MASK_RST = 8'h00;
   localparam logic [STD_W-1:0] STD_RST = 8'h00;
   localparam logic [DEV_W-1:0] DEV_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // ------------------------------------------------------------
   // host commands and queries
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SSR_CMD_CLEAR_STATUS,
      SSR_CMD_WRITE_SRQ_MASK,
      SSR_CMD_WRITE_STD_MASK,
      SSR_CMD_WRITE_DEV_MASK
   } ssr_cmd_t;

   typedef enum logic [2:0] {
      SSR_QRY_STATUS_BYTE,
      SSR_QRY_STD_LATCH,
      SSR_QRY_DEV_LATCH,
      SSR_QRY_SRQ_MASK,
      SSR_QRY_STD_MASK,
      SSR_QRY_DEV_MASK
   } ssr_qry_t;

endpackage : ssr_pkg

// *** rtl/ssr_event_if.sv ***
// carrier between the top and one event register group
`timescale 1ns/1ps
interface ssr_event_if #(parameter int W = 8);
   logic [W-1:0] event_set;
   logic [W-1:0] used_bits;
   logic mask_write;
   logic [W-1:0] mask_data;
   logic read_clear;
   logic clear_status;
   logic [W-1:0] latch;
   logic [W-1:0] mask;
   logic summary;

   modport top (
      output event_set, used_bits, mask_write, mask_data,
      output read_clear, clear_status,
      input latch, mask, summary
   );
   modport grp (
      input event_set, used_bits, mask_write, mask_data,
      input read_clear, clear_status,
      output latch, mask, summary
   );
endinterface : ssr_event_if

// *** rtl/ssr_event_group.sv ***
// one latched event register with its enable mask and summary
`timescale 1ns/1ps
module ssr_event_group
   import ssr_pkg::*;
#(
   parameter int W = 8
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // group carrier
   ssr_event_if.grp eg
);

   typedef struct packed {
      logic [W-1:0] latch;
      logic [W-1:0] mask;
   } ssr_group_state_t;

   ssr_group_state_t st;
   ssr_group_state_t next_st;

   // ------------------------------------------------------------
   // latch, clear and mask update
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (eg.read_clear || eg.clear_status) begin
         next_st.latch = '0;
      end
      // a new event wins over a clear in the same cycle
      next_st.latch = next_st.latch | (eg.event_set & eg.used_bits);
      if (eg.mask_write) begin
         next_st.mask = eg.mask_data & eg.used_bits;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs, no host write path reaches the latch
   // ------------------------------------------------------------
   assign eg.latch = st.latch;
   assign eg.mask = st.mask;
   assign eg.summary = |(st.latch & st.mask);

endmodule : ssr_event_group

// *** rtl/ssr_status_top.sv ***
// status byte, master summary, service request and serial poll answer
`timescale 1ns/1ps
module ssr_status_top
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // event sources, one-cycle set pulses
   input wire logic [STD_W-1:0] std_event_set,
   input wire logic [DEV_W-1:0] dev_event_set,
   // output buffer holds response data
   input wire logic out_buf_not_empty,
   // host commands
   input wire logic cmd_valid,
   input wire ssr_cmd_t cmd_sel,
   input wire logic [DATA_W-1:0] cmd_data,
   // host queries
   input wire logic qry_valid,
   input wire ssr_qry_t qry_sel,
   output logic qry_resp_valid,
   output logic [DATA_W-1:0] qry_resp_data,
   // serial poll
   input wire logic poll_req,
   output logic poll_resp_valid,
   output logic [STB_W-1:0] poll_resp_data,
   // service request line and status byte view
   output logic service_request,
   output logic [STB_W-1:0] service_status_byte,
   output logic master_summary
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic rqs;
      logic mss_prev;
      logic [STB_W-1:0] srq_mask;
      logic [STB_W-1:0] stb;
      logic resp_valid;
      logic [DATA_W-1:0] resp_data;
      logic poll_valid;
      logic [STB_W-1:0] poll_data;
   } ssr_state_t;

   ssr_state_t st;
   ssr_state_t next_st;

   ssr_event_if #(.W(STD_W)) std_if ();
   ssr_event_if #(.W(DEV_W)) dev_if ();

   logic clear_status;
   logic [STB_W-1:0] live_stb;
   logic [STB_W-1:0] eff_srq_mask;
   logic mss;

   // ------------------------------------------------------------
   // event groups
   // ------------------------------------------------------------
   assign clear_status = cmd_valid && (cmd_sel == SSR_CMD_CLEAR_STATUS);

   assign std_if.event_set = std_event_set;
   assign std_if.used_bits = STD_USED;
   assign std_if.mask_write = cmd_valid &&
      (cmd_sel == SSR_CMD_WRITE_STD_MASK);
   assign std_if.mask_data = cmd_data[STD_W-1:0];
   assign std_if.read_clear = qry_valid &&
      (qry_sel == SSR_QRY_STD_LATCH);
   assign std_if.clear_status = clear_status;

   assign dev_if.event_set = dev_event_set;
   assign dev_if.used_bits = DEV_USED;
   assign dev_if.mask_write = cmd_valid &&
      (cmd_sel == SSR_CMD_WRITE_DEV_MASK);
   assign dev_if.mask_data = cmd_data[DEV_W-1:0];
   assign dev_if.read_clear = qry_valid &&
      (qry_sel == SSR_QRY_DEV_LATCH);
   assign dev_if.clear_status = clear_status;

   ssr_event_group #(.W(STD_W)) u_std_group (
      .mclk(mclk),
      .rst(rst),
      .eg(std_if.grp)
   );

   ssr_event_group #(.W(DEV_W)) u_dev_group (
      .mclk(mclk),
      .rst(rst),
      .eg(dev_if.grp)
   );

   // ------------------------------------------------------------
   // live status byte and master summary
   // ------------------------------------------------------------
   always_comb begin
      live_stb = '0;
      live_stb[STB_DEV_SUM_BIT] = dev_if.summary;
      live_stb[STB_MAV_BIT] = out_buf_not_empty;
      live_stb[STB_STD_SUM_BIT] = std_if.summary;
      eff_srq_mask = st.srq_mask;
      eff_srq_mask[STB_MSS_BIT] = 1'b1;
      mss = |(live_stb & eff_srq_mask);
      live_stb[STB_MSS_BIT] = mss;
   end

   // ------------------------------------------------------------
   // request flag, mask, query and poll answers
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.resp_valid = 1'b0;
      next_st.poll_valid = 1'b0;
      next_st.mss_prev = mss;
      next_st.stb = live_stb;
      if (cmd_valid && (cmd_sel == SSR_CMD_WRITE_SRQ_MASK)) begin
         next_st.srq_mask = cmd_data[STB_W-1:0];
         next_st.srq_mask[STB_MSS_BIT] = 1'b0;
      end
      if (poll_req) begin
         next_st.poll_valid = 1'b1;
         next_st.poll_data = live_stb;
         next_st.poll_data[STB_MSS_BIT] = st.rqs;
         next_st.rqs = 1'b0;
      end
      if (clear_status) begin
         next_st.rqs = 1'b0;
         next_st.mss_prev = 1'b0;
         next_st.stb = '0;
         next_st.stb[STB_MAV_BIT] = out_buf_not_empty;
      end
      // a fresh master summary edge wins over poll and clear
      if (mss && !st.mss_prev) begin
         next_st.rqs = 1'b1;
      end
      if (qry_valid) begin
         next_st.resp_valid = 1'b1;
         case (qry_sel)
            SSR_QRY_STATUS_BYTE: begin
               next_st.resp_data = {8'h00, live_stb};
            end
            SSR_QRY_STD_LATCH: begin
               next_st.resp_data = {8'h00, std_if.latch};
            end
            SSR_QRY_DEV_LATCH: begin
               next_st.resp_data = dev_if.latch;
            end
            SSR_QRY_SRQ_MASK: begin
               next_st.resp_data = {8'h00, st.srq_mask};
            end
            SSR_QRY_STD_MASK: begin
               next_st.resp_data = {8'h00, std_if.mask};
            end
            SSR_QRY_DEV_MASK: begin
               next_st.resp_data = dev_if.mask;
            end
            default: begin
               next_st.resp_data = DATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st.rqs <= 1'b0;
         st.mss_prev <= 1'b0;
         st.srq_mask <= SRQ_MASK_RST;
         st.stb <= STB_RST;
         st.resp_valid <= 1'b0;
         st.resp_data <= DATA_RST;
         st.poll_valid <= 1'b0;
         st.poll_data <= STB_RST;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign service_request = st.rqs;
   assign service_status_byte = st.stb;
   assign master_summary = st.stb[STB_MSS_BIT];
   assign qry_resp_valid = st.resp_valid;
   assign qry_resp_data = st.resp_data;
   assign poll_resp_valid = st.poll_valid;
   assign poll_resp_data = st.poll_data;

endmodule : ssr_status_top

// *** test/ssr_status_top_sva.sv ***
// assertions on the status top ports
`timescale 1ns/1ps
module ssr_status_sva
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // host side
   input wire logic out_buf_not_empty,
   input wire logic cmd_valid,
   input wire ssr_cmd_t cmd_sel,
   input wire logic qry_valid,
   input wire ssr_qry_t qry_sel,
   input wire logic qry_resp_valid,
   input wire logic [DATA_W-1:0] qry_resp_data,
   input wire logic poll_req,
   input wire logic poll_resp_valid,
   input wire logic [STB_W-1:0] poll_resp_data,
   // status
   input wire logic service_request,
   input wire logic [STB_W-1:0] service_status_byte,
   input wire logic master_summary
);
   // -------------------------------------------
   // properties
   // -------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_poll;
      (poll_req && !(cmd_valid && cmd_sel == SSR_CMD_CLEAR_STATUS))
         ##1 poll_resp_valid;
   endsequence
   sequence s_cls;
      cmd_valid && cmd_sel == SSR_CMD_CLEAR_STATUS;
   endsequence
   property p_mss;
      master_summary == service_status_byte[6]
         && (service_status_byte & 8'h87) == 8'h00
         && (!master_summary || |service_status_byte[5:3]);
   endproperty
   property p_poll;
      poll_req |=> poll_resp_valid;
   endproperty
   property p_poll_bits;
      s_poll |-> poll_resp_data[5:0] == service_status_byte[5:0]
         && poll_resp_data[7] == service_status_byte[7]
         && poll_resp_data[6] == $past(service_request);
   endproperty
   property p_rqs_clr;
      poll_req && !(cmd_valid && cmd_sel == SSR_CMD_CLEAR_STATUS)
         |=> service_request == (master_summary && !$past(master_summary));
   endproperty
   property p_rqs_set;
      $rose(master_summary) |-> service_request;
   endproperty
   property p_cls;
      s_cls |=> (service_status_byte & 8'hEF) == 8'h00
         && (!service_request || !$past(master_summary));
   endproperty
   property p_mav;
      !$past(rst) |-> service_status_byte[4] == $past(out_buf_not_empty);
   endproperty
   property p_stb_qry;
      qry_valid && qry_sel == SSR_QRY_STATUS_BYTE
         && !(cmd_valid && cmd_sel == SSR_CMD_CLEAR_STATUS)
         |=> qry_resp_valid && qry_resp_data == {8'h00, service_status_byte};
   endproperty
   a_mss: assert property (p_mss) else $error("mss off");
   a_poll: assert property (p_poll) else $error("no poll");
   a_poll_bits: assert property (p_poll_bits) else $error("poll");
   a_rqs_clr: assert property (p_rqs_clr) else $error("rqs");
   a_rqs_set: assert property (p_rqs_set) else $error("no rqs");
   a_cls: assert property (p_cls) else $error("clear");
   a_mav: assert property (p_mav) else $error("mav");
   a_stb_qry: assert property (p_stb_qry) else $error("stb");
endmodule : ssr_status_sva
bind ssr_status_top ssr_status_sva u_sva (.mclk, .rst,
   .out_buf_not_empty, .cmd_valid, .cmd_sel, .qry_valid, .qry_sel,
   .qry_resp_valid, .qry_resp_data, .poll_req, .poll_resp_valid,
   .poll_resp_data, .service_request, .service_status_byte,
   .master_summary);

// *** test/ssr_host_model.sv ***
// remote host controller issuing commands, queries and polls
`timescale 1ns/1ps
module ssr_host_model
   import ssr_pkg::*;
#(
   parameter int QRY_GAP = 4
) (
   // clock
   input wire logic mclk,
   // commands and queries
   output logic cmd_valid,
   output ssr_cmd_t cmd_sel,
   output logic [DATA_W-1:0] cmd_data,
   output logic qry_valid,
   output ssr_qry_t qry_sel,
   input wire logic qry_resp_valid,
   input wire logic [DATA_W-1:0] qry_resp_data,
   // serial poll
   output logic poll_req,
   input wire logic poll_resp_valid,
   input wire logic [STB_W-1:0] poll_resp_data
);
   int gap = 0;
   initial begin
      cmd_valid = 1'b0;
      cmd_sel = SSR_CMD_CLEAR_STATUS;
      cmd_data = 16'h0000;
      qry_valid = 1'b0;
      qry_sel = SSR_QRY_STATUS_BYTE;
      poll_req = 1'b0;
   end
   always @(posedge mclk) gap <= cmd_valid ? 0 : gap + 1;
   // mask value travels with its command
   task cmd(input ssr_cmd_t s, input logic [DATA_W-1:0] v);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_sel <= s;
      cmd_data <= v;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_data <= ~v;
   endtask : cmd
   task qry(input ssr_qry_t s, output logic [DATA_W-1:0] v);
      while (gap < QRY_GAP) @(posedge mclk);
      @(posedge mclk);
      qry_valid <= 1'b1;
      qry_sel <= s;
      @(posedge mclk);
      qry_valid <= 1'b0;
      v = 'x;
      @(negedge mclk);
      if (qry_resp_valid === 1'b1) v = qry_resp_data;
   endtask : qry
   task poll(output logic [STB_W-1:0] v);
      @(posedge mclk);
      poll_req <= 1'b1;
      @(posedge mclk);
      poll_req <= 1'b0;
      v = 'x;
      @(negedge mclk);
      if (poll_resp_valid === 1'b1) v = poll_resp_data;
   endtask : poll
endmodule : ssr_host_model

// *** test/tb_ssr_status_top.sv ***
// self-checking bench for the status summary block
`timescale 1ns/1ps
module tb_ssr_status_top
   import ssr_pkg::*;
;
   logic mclk, rst, out_buf_not_empty, cmd_valid, qry_valid, poll_req;
   logic qry_resp_valid, poll_resp_valid, service_request, master_summary;
   ssr_cmd_t cmd_sel;
   ssr_qry_t qry_sel;
   logic [STD_W-1:0] std_event_set, sl, sm, e8;
   logic [DEV_W-1:0] dev_event_set, dl, dm, e16;
   logic [DATA_W-1:0] cmd_data, qry_resp_data, d;
   logic [STB_W-1:0] poll_resp_data, service_status_byte, rm, eb, pb;
   int num_errors = 0;
   int num_checks = 0;
   int seed;
   ssr_status_top uut (.mclk, .rst, .std_event_set, .dev_event_set,
      .out_buf_not_empty, .cmd_valid, .cmd_sel, .cmd_data, .qry_valid,
      .qry_sel, .qry_resp_valid, .qry_resp_data, .poll_req,
      .poll_resp_valid, .poll_resp_data, .service_request,
      .service_status_byte, .master_summary);
   ssr_host_model host (.mclk, .cmd_valid, .cmd_sel, .cmd_data,
      .qry_valid, .qry_sel, .qry_resp_valid, .qry_resp_data, .poll_req,
      .poll_resp_valid, .poll_resp_data);
   // -------------------------------------------
   // checks and expectations
   // -------------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task end_of_test();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   function automatic logic [7:0] exp_stb();
      logic [7:0] b;
      b = 8'h00;
      b[3] = |(dl & dm);
      b[4] = out_buf_not_empty;
      b[5] = |(sl & sm);
      b[6] = |(b & rm & 8'hBF);
      return b;
   endfunction : exp_stb
   task pulse(input logic [7:0] s, input logic [15:0] v);
      @(posedge mclk);
      std_event_set <= s;
      dev_event_set <= v;
      @(posedge mclk);
      std_event_set <= 8'h00;
      dev_event_set <= 16'h0000;
      repeat (2) @(posedge mclk);
   endtask : pulse
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      out_buf_not_empty = 1'b0;
      std_event_set = 8'h00;
      dev_event_set = 16'h0000;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      seed = $urandom(94524);
      @(negedge mclk);
      chk(16'(service_status_byte), 16'(STB_RST));
      host.qry(SSR_QRY_SRQ_MASK, d);
      chk(d, 16'(SRQ_MASK_RST));
      for (int i = 0; i < 24; i++) begin
         @(posedge mclk);
         out_buf_not_empty <= 1'b0;
         host.cmd(SSR_CMD_CLEAR_STATUS, 16'h0000);
         rm = i < 2 ? {8{i == 0}} : 8'($urandom);
         sm = (i < 2 ? {8{i == 0}} : 8'($urandom)) & STD_USED;
         dm = (i < 2 ? {16{i == 0}} : 16'($urandom)) & DEV_USED;
         e8 = i < 2 ? 8'hFF : 8'($urandom);
         e16 = i < 2 ? 16'hFFFF : 16'($urandom);
         host.cmd(SSR_CMD_WRITE_SRQ_MASK, {8'h00, rm});
         host.cmd(SSR_CMD_WRITE_STD_MASK, {8'hFF, sm});
         host.cmd(SSR_CMD_WRITE_DEV_MASK, dm);
         out_buf_not_empty <= 1'($urandom);
         sl = e8 & STD_USED;
         dl = e16 & DEV_USED;
         pulse(e8, e16);
         @(negedge mclk);
         eb = exp_stb();
         chk(16'(service_status_byte), 16'(eb));
         chk(16'(master_summary), 16'(eb[6]));
         chk(16'(service_request), 16'(eb[6]));
         host.poll(pb);
         chk(16'(pb), 16'(eb));
         chk(16'(service_request), 16'h0000);
         chk(16'(service_status_byte), 16'(eb));
         host.qry(SSR_QRY_STATUS_BYTE, d);
         chk(d, 16'(eb));
         host.qry(SSR_QRY_SRQ_MASK, d);
         chk(d, 16'(rm & 8'hBF));
         host.qry(SSR_QRY_STD_MASK, d);
         chk(d, 16'(sm));
         host.qry(SSR_QRY_STD_LATCH, d);
         chk(d, 16'(sl));
         sl = 8'h00;
         @(negedge mclk);
         chk(16'(service_status_byte), 16'(exp_stb()));
         dm = ~dl & DEV_USED;
         host.cmd(SSR_CMD_WRITE_DEV_MASK, ~dl);
         host.qry(SSR_QRY_DEV_MASK, d);
         chk(d, dm);
         host.qry(SSR_QRY_DEV_LATCH, d);
         chk(d, dl);
         dl = 16'h0000;
         @(negedge mclk);
         chk(16'(service_status_byte), 16'(exp_stb()));
         host.qry(SSR_QRY_DEV_LATCH, d);
         chk(d, 16'h0000);
      end
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      chk(16'(service_status_byte), 16'(STB_RST));
      host.qry(SSR_QRY_SRQ_MASK, d);
      chk(d, 16'(SRQ_MASK_RST));
      @(posedge mclk);
      out_buf_not_empty <= 1'b1;
      pulse(8'hFF, 16'hFFFF);
      host.cmd(SSR_CMD_CLEAR_STATUS, 16'h0000);
      @(negedge mclk);
      chk(16'(service_status_byte), 16'h0010);
      chk(16'(service_request), 16'h0000);
      host.qry(SSR_QRY_STD_LATCH, d);
      chk(d, 16'h0000);
      end_of_test();
   end
endmodule : tb_ssr_status_top
